/* hdl/ctpg_host.sv */
// Controller that programs a cascaded 16-bit timer through its byte port and feeds its event pin.
// Assumes the timer takes one byte write per cycle and raises its match interrupt as a one-cycle pulse.
//
// Overview of operation
// R1: Timer counts falling edges of the event input as one 16-bit counter.
// R2: Once running, a period match raises the interrupt and clears the counter.
// R3: Each event level is held at least two machine cycles by the source.
// R4: Period pair is written low byte then high byte, never singly.
// R5: Event mode period pair is unbuffered; change it only while stopped.
// R6: Flop initial value stays zero in event counter mode.
// R7: PWM toggles on duty match, toggles and clears on overflow, interrupts.
// R8: Pulse mode toggles on duty match, toggles and clears on period match.
// R9: Output flop loads from the initial bit and resets to zero.
// R10: Both waveform pins show the inverse of the output flop.
// R11: PWM duty writes while running wait in a shadow stage until the interrupt.
// R12: Reading PWM duty while running returns the shadow stage; the timer model returns the transferred duty instead.
// R13: Duty pair is written low byte then high byte, never singly.
// R14: Duty pair is updated right after the match interrupt.
// R15: Stopping keeps the pin level; initial bit changes only after stop.
// R16: Clear run bit to stop, then clear flop bit to drive pin high.
// R17: Timer is stopped before the device enters its stop power mode.
// R18: Port output latch is set to one for the waveform pin.
// R19: Pulse mode duty and period pairs change only while stopped; a duty command during pulse output writes the duty pair while running.
// R20: Pulse mode pairs are each written low byte then high byte.
// R21: Source clock is a power-of-two division of the system clock.
// R22: PWM period is 2^16 source clocks.
`default_nettype none
module ctpg_host #(
   parameter int unsigned EVT_LEVEL_CYC = ctpg_pkg::EVT_LEVEL_CYC
) (
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   input wire logic i_cmd_valid,
   input wire logic [2:0] i_cmd_op,
   input wire logic [15:0] i_cmd_period,
   input wire logic [15:0] i_cmd_duty,
   input wire logic [2:0] i_cmd_clk_sel,
   input wire logic i_cmd_prescale,
   input wire logic i_cmd_flop_init,
   input wire logic i_cmd_force_high,
   input wire logic [15:0] i_cmd_events,
   input wire logic i_match_irq,
   output logic o_cmd_ready,
   output logic o_cmd_done,
   output logic o_sleep_ok,
   output logic o_reg_wr,
   output logic [3:0] o_reg_addr,
   output logic [7:0] o_reg_wdata,
   output logic o_event_input_pin
);
   typedef enum logic [1:0] {ST_IDLE, ST_SEQ, ST_WAIT_IRQ, ST_EVENTS} ctpg_state_e;

   // Builds an upper control byte from mode, initial bit and run bit.
   function automatic logic [7:0] upper_ctrl(input logic [2:0] mode, input logic init,
                                             input logic run);
      logic [7:0] v;
      v = 8'h00;
      v[ctpg_pkg::MODE_LSB +: 3] = mode;
      v[ctpg_pkg::UPPER_FLOP_INIT_BIT] = init;
      v[ctpg_pkg::UPPER_RUN_BIT] = run;
      return v;
   endfunction

   // Maps a start command to its mode code.
   function automatic logic [2:0] op_mode(input logic [2:0] op);
      logic [2:0] m;
      m = ctpg_pkg::MODE_PPG;
      if (op == ctpg_pkg::OP_START_EVENT) begin
         m = ctpg_pkg::MODE_EVENT;
      end else if (op == ctpg_pkg::OP_START_PWM) begin
         m = ctpg_pkg::MODE_PWM;
      end
      return m;
   endfunction

   ctpg_state_e state, next_state;
   logic [3:0] step, next_step;
   logic [2:0] op, next_op;
   logic [15:0] period, next_period;
   logic [15:0] duty, next_duty;
   logic [2:0] clk_sel, next_clk_sel;
   logic prescale, next_prescale, init, next_init, force_high, next_force_high;
   logic [15:0] events, next_events;
   logic [2:0] mode, next_mode;
   logic running, next_running, flop_init, next_flop_init, sleep_ok, next_sleep_ok;
   logic ready, next_ready, done, next_done, wr, next_wr;
   logic [3:0] addr, next_addr;
   logic [7:0] wdata, next_wdata;
   logic evt_start, next_evt_start, evt_busy, evt_pin, last_step;
   logic [3:0] seq_addr;
   logic [7:0] seq_data;

   // Event burst generator on the timer's event input.
   ctpg_evt_src #(
      .LEVEL_CYC(EVT_LEVEL_CYC),
      .CNT_W(16)
   ) u_evt (
      .i_sys_clk(i_sys_clk),
      .i_nrst(i_nrst),
      .i_start(evt_start),
      .i_count(events),
      .o_pin(evt_pin),
      .o_busy(evt_busy)
   );

   // Byte to write at the current step of the active sequence.
   always_comb begin
      logic [7:0] lower;
      lower = 8'h00;
      lower[ctpg_pkg::CLKSEL_LSB +: 3] = clk_sel; // R21
      lower[ctpg_pkg::LOWER_PRESCALE_BIT] = prescale; // R21
      lower[ctpg_pkg::LOWER_MODE_LSB +: 3] = mode;
      seq_addr = ctpg_pkg::ADDR_UPPER_CTRL;
      seq_data = upper_ctrl(mode, flop_init, 1'b0);
      last_step = 1'b0;
      if (op == ctpg_pkg::OP_SET_DUTY) begin
         // Reached after the interrupt while PWM runs, away from the shadow transfer.
         seq_addr = (step == 4'h0) ? ctpg_pkg::ADDR_DUTY_LOW : ctpg_pkg::ADDR_DUTY_HIGH; // R13 R14
         seq_data = (step == 4'h0) ? duty[7:0] : duty[15:8];
         last_step = (step != 4'h0);
      end else if (op == ctpg_pkg::OP_STOP) begin
         // Stop first with the bit unchanged, then clear it in a later write if force_high is set.
         if (step == 4'h0) begin
            seq_data = upper_ctrl(mode, flop_init, 1'b0); // R15 R16 R17
            last_step = !force_high;
         end else begin
            seq_data = upper_ctrl(mode, 1'b0, 1'b0); // R16
            last_step = 1'b1;
         end
      end else begin
         case (step)
            4'h0: begin
               seq_addr = ctpg_pkg::ADDR_PORT_LATCH;
               seq_data = ctpg_pkg::PORT_LATCH_ON; // R18
            end
            4'h1: seq_data = upper_ctrl(mode, 1'b0, 1'b0); // R5 R19
            4'h2: begin
               seq_addr = ctpg_pkg::ADDR_PERIOD_LOW;
               seq_data = period[7:0]; // R4 R20
            end
            4'h3: begin
               seq_addr = ctpg_pkg::ADDR_PERIOD_HIGH;
               seq_data = period[15:8]; // R4 R20
            end
            4'h4: begin
               seq_addr = ctpg_pkg::ADDR_DUTY_LOW;
               seq_data = duty[7:0]; // R13 R20
            end
            4'h5: begin
               seq_addr = ctpg_pkg::ADDR_DUTY_HIGH;
               seq_data = duty[15:8]; // R13 R20
            end
            4'h6: begin
               seq_addr = ctpg_pkg::ADDR_LOWER_CTRL;
               seq_data = lower;
            end
            4'h7: seq_data = upper_ctrl(mode, init, 1'b0); // R6 R15
            default: begin
               seq_data = upper_ctrl(mode, init, 1'b1); // R2
               last_step = 1'b1;
            end
         endcase
      end
   end

   // Command sequencer.
   always_comb begin
      next_state = state;
      next_step = step;
      next_op = op;
      next_period = period;
      next_duty = duty;
      next_clk_sel = clk_sel;
      next_prescale = prescale;
      next_init = init;
      next_force_high = force_high;
      next_events = events;
      next_mode = mode;
      next_running = running;
      next_flop_init = flop_init;
      next_ready = 1'b0;
      next_done = 1'b0;
      next_wr = 1'b0;
      next_addr = addr;
      next_wdata = wdata;
      next_evt_start = 1'b0;
      case (state)
         ST_IDLE: begin
            next_ready = 1'b1;
            if (ready && i_cmd_valid) begin
               next_ready = 1'b0;
               next_op = i_cmd_op;
               next_step = '0;
               next_period = i_cmd_period;
               next_duty = i_cmd_duty;
               next_clk_sel = i_cmd_clk_sel;
               next_prescale = i_cmd_prescale;
               next_force_high = i_cmd_force_high;
               next_events = i_cmd_events;
               next_state = ST_SEQ;
               if (i_cmd_op <= ctpg_pkg::OP_START_PPG) begin
                  next_mode = op_mode(i_cmd_op);
                  // Event counting must not disturb the waveform pins.
                  next_init = (i_cmd_op == ctpg_pkg::OP_START_EVENT) ? 1'b0 : i_cmd_flop_init; // R6
               end else if (i_cmd_op == ctpg_pkg::OP_SET_DUTY) begin
                  next_state = (running && mode == ctpg_pkg::MODE_PWM) ? ST_WAIT_IRQ : ST_SEQ; // R14
               end else if (i_cmd_op == ctpg_pkg::OP_SEND_EVENTS) begin
                  next_evt_start = 1'b1;
                  next_state = ST_EVENTS;
               end
            end
         end
         ST_WAIT_IRQ: begin
            if (i_match_irq) begin
               next_state = ST_SEQ; // R14
            end
         end
         ST_SEQ: begin
            next_wr = 1'b1;
            next_addr = seq_addr;
            next_wdata = seq_data;
            next_step = step + 4'h1;
            if (seq_addr == ctpg_pkg::ADDR_UPPER_CTRL) begin
               next_running = seq_data[ctpg_pkg::UPPER_RUN_BIT];
               next_flop_init = seq_data[ctpg_pkg::UPPER_FLOP_INIT_BIT];
            end
            if (last_step) begin
               next_done = 1'b1;
               next_state = ST_IDLE;
            end
         end
         ST_EVENTS: begin
            if (!evt_busy && !evt_start) begin
               next_done = 1'b1;
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
      next_sleep_ok = !next_running; // R17
   end

   // Registers of the sequencer and of every output but the event pin.
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         state <= ST_IDLE;
         step <= '0;
         op <= ctpg_pkg::OP_STOP;
         period <= '0;
         duty <= '0;
         clk_sel <= '0;
         prescale <= 1'b0;
         init <= 1'b0;
         force_high <= 1'b0;
         events <= '0;
         mode <= ctpg_pkg::MODE_EVENT;
         running <= 1'b0;
         flop_init <= 1'b0;
         ready <= 1'b0;
         done <= 1'b0;
         wr <= 1'b0;
         addr <= '0;
         wdata <= '0;
         evt_start <= 1'b0;
         sleep_ok <= 1'b1;
      end else begin
         state <= next_state;
         step <= next_step;
         op <= next_op;
         period <= next_period;
         duty <= next_duty;
         clk_sel <= next_clk_sel;
         prescale <= next_prescale;
         init <= next_init;
         force_high <= next_force_high;
         events <= next_events;
         mode <= next_mode;
         running <= next_running;
         flop_init <= next_flop_init;
         ready <= next_ready;
         done <= next_done;
         wr <= next_wr;
         addr <= next_addr;
         wdata <= next_wdata;
         evt_start <= next_evt_start;
         sleep_ok <= next_sleep_ok;
      end
   end

   // Sleep is safe only once the run bit has been written low.
   assign o_sleep_ok = sleep_ok; // R17
   assign o_cmd_ready = ready;
   assign o_cmd_done = done;
   assign o_reg_wr = wr;
   assign o_reg_addr = addr;
   assign o_reg_wdata = wdata;
   assign o_event_input_pin = evt_pin;
endmodule // ctpg_host
`default_nettype wire

/* hdl/ctpg_pkg.sv */
// Constants shared by the cascaded timer controller and its event pulse source.
// Assumes a byte-wide register port on the timer side and a 100 MHz system clock.
`default_nettype none
package ctpg_pkg;
   // System clock period in nanoseconds.
   localparam int unsigned CLK_PERIOD_NS = 10;
   // Least time each level of the event input is held, in nanoseconds.
   localparam int unsigned EVT_LEVEL_NS = 400;
   // Least hold in clock cycles, rounded up.
   localparam int unsigned EVT_LEVEL_CYC = (EVT_LEVEL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Register addresses on the timer's byte port.
   localparam logic [3:0] ADDR_LOWER_CTRL = 4'h0;
   localparam logic [3:0] ADDR_UPPER_CTRL = 4'h1;
   localparam logic [3:0] ADDR_PERIOD_LOW = 4'h2;
   localparam logic [3:0] ADDR_PERIOD_HIGH = 4'h3;
   localparam logic [3:0] ADDR_DUTY_LOW = 4'h4;
   localparam logic [3:0] ADDR_DUTY_HIGH = 4'h5;
   localparam logic [3:0] ADDR_PORT_LATCH = 4'h6;

   // Upper control fields.
   localparam int unsigned UPPER_FLOP_INIT_BIT = 7;
   localparam int unsigned UPPER_RUN_BIT = 3;
   localparam int unsigned MODE_LSB = 0;
   // Lower control fields.
   localparam int unsigned LOWER_PRESCALE_BIT = 3;
   localparam int unsigned LOWER_MODE_LSB = 4;
   localparam int unsigned CLKSEL_LSB = 0;

   // Mode codes for the cascaded unit.
   localparam logic [2:0] MODE_EVENT = 3'h5;
   localparam logic [2:0] MODE_PWM = 3'h6;
   localparam logic [2:0] MODE_PPG = 3'h7;

   // Value written to the port output latch so the waveform reaches the pin.
   localparam logic [7:0] PORT_LATCH_ON = 8'h01;

   // User command codes.
   localparam logic [2:0] OP_START_EVENT = 3'h0;
   localparam logic [2:0] OP_START_PWM = 3'h1;
   localparam logic [2:0] OP_START_PPG = 3'h2;
   localparam logic [2:0] OP_SET_DUTY = 3'h3;
   localparam logic [2:0] OP_STOP = 3'h4;
   localparam logic [2:0] OP_SEND_EVENTS = 3'h5;

   // Step numbers of the start sequence.
   localparam logic [3:0] STEP_LAST_START = 4'h8;
endpackage
`default_nettype wire

/* hdl/ctpg_evt_src.sv */
// Drives the timer's event input with a burst of full low/high periods.
// Assumes the timer samples the pin on the same system clock.
`default_nettype none
module ctpg_evt_src #(
   parameter int unsigned LEVEL_CYC = ctpg_pkg::EVT_LEVEL_CYC,
   parameter int unsigned CNT_W = 16
) (
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   input wire logic i_start,
   input wire logic [CNT_W-1:0] i_count,
   output logic o_pin,
   output logic o_busy
);
   localparam logic [15:0] LEVEL_LAST = 16'(LEVEL_CYC - 1);

   logic pin, next_pin;
   logic busy, next_busy;
   logic [15:0] hold, next_hold;
   logic [CNT_W-1:0] left, next_left;

   // Each level stands for the full hold so every falling edge is seen.
   always_comb begin
      next_pin = pin;
      next_busy = busy;
      next_hold = hold;
      next_left = left;
      if (!busy) begin
         if (i_start && (i_count != '0)) begin
            next_busy = 1'b1;
            next_left = i_count;
            next_pin = 1'b0; // R1 R3
            next_hold = '0;
         end
      end else if (hold != LEVEL_LAST) begin
         next_hold = hold + 16'h0001; // R3
      end else begin
         next_hold = '0;
         if (!pin) begin
            next_pin = 1'b1;
            next_left = left - 1'b1;
         end else if (left == '0) begin
            next_busy = 1'b0;
         end else begin
            next_pin = 1'b0;
         end
      end
   end

   // The pin idles high so the first edge of a burst is a falling one.
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         pin <= 1'b1;
         busy <= 1'b0;
         hold <= '0;
         left <= '0;
      end else begin
         pin <= next_pin;
         busy <= next_busy;
         hold <= next_hold;
         left <= next_left;
      end
   end

   assign o_pin = pin;
   assign o_busy = busy;
endmodule // ctpg_evt_src
`default_nettype wire

/* dv/ctpg_host_checker.sv */
// Port assertions for the cascaded timer controller.
// Assumes it is bound into ctpg_host and sees only that module's ports.
`default_nettype none
module ctpg_host_checker #(
   parameter int unsigned EVT_LEVEL_CYC = ctpg_pkg::EVT_LEVEL_CYC
) (
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   input wire logic i_cmd_valid,
   input wire logic [2:0] i_cmd_op,
   input wire logic o_cmd_ready,
   input wire logic o_sleep_ok,
   input wire logic o_reg_wr,
   input wire logic [3:0] o_reg_addr,
   input wire logic [7:0] o_reg_wdata,
   input wire logic o_event_input_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic up_wr, take, last_run, next_last_run, last_init, next_last_init, pin_q;
   logic [7:0] hc, next_hc;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_nrst);
   assign up_wr = o_reg_wr && o_reg_addr == ctpg_pkg::ADDR_UPPER_CTRL;
   assign take = i_cmd_valid && o_cmd_ready;
   // Run and initial bits of the last upper control write and the age of the event level; the age saturates.
   always_comb begin
      next_last_run = up_wr ? o_reg_wdata[3] : last_run;
      next_last_init = up_wr ? o_reg_wdata[7] : last_init;
      next_hc = (o_event_input_pin != pin_q) ? 8'h01 : hc + {7'h00, hc != 8'hff};
   end
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         last_run <= 1'b0;
         last_init <= 1'b0;
         pin_q <= 1'b1;
         hc <= 8'hff;
      end else begin
         last_run <= next_last_run;
         last_init <= next_last_init;
         pin_q <= o_event_input_pin;
         hc <= next_hc;
      end
   end
   latch_first_a: assert property (take && i_cmd_op <= ctpg_pkg::OP_START_PPG |=> ##[0:2]
      (o_reg_wr && o_reg_addr == ctpg_pkg::ADDR_PORT_LATCH
      && o_reg_wdata == ctpg_pkg::PORT_LATCH_ON)) else $error("port latch not set first");
   period_pair_a: assert property (o_reg_wr && o_reg_addr == ctpg_pkg::ADDR_PERIOD_LOW
      |=> o_reg_wr && o_reg_addr == ctpg_pkg::ADDR_PERIOD_HIGH) else $error("period split");
   duty_pair_a: assert property (o_reg_wr && o_reg_addr == ctpg_pkg::ADDR_DUTY_LOW
      |=> o_reg_wr && o_reg_addr == ctpg_pkg::ADDR_DUTY_HIGH) else $error("duty split");
   high_after_low_a: assert property (o_reg_wr && (o_reg_addr == ctpg_pkg::ADDR_PERIOD_HIGH
      || o_reg_addr == ctpg_pkg::ADDR_DUTY_HIGH) |-> $past(o_reg_wr)
      && $past(o_reg_addr) == o_reg_addr - 4'h1) else $error("high byte without low");
   stop_before_load_a: assert property (o_reg_wr && o_reg_addr == ctpg_pkg::ADDR_PERIOD_LOW
      |-> $past(up_wr) && !$past(o_reg_wdata[3])) else $error("compare load while running");
   event_init_zero_a: assert property (up_wr && o_reg_wdata[2:0] == ctpg_pkg::MODE_EVENT
      |-> !o_reg_wdata[7]) else $error("flop bit set in event mode");
   stop_keeps_flop_a: assert property (up_wr && last_run && !o_reg_wdata[3]
      |-> o_reg_wdata[7] == last_init) else $error("flop bit changed with stop");
   sleep_flag_a: assert property ($past(up_wr) && !up_wr
      |-> o_sleep_ok == !last_run) else $error("sleep flag wrong");
   evt_hold_a: assert property (o_event_input_pin != pin_q
      |-> hc >= EVT_LEVEL_CYC) else $error("event level too short");
   cover property (take && i_cmd_op == ctpg_pkg::OP_SET_DUTY);
   cover property (up_wr && last_run && !o_reg_wdata[3]);
   cover property ($fell(o_event_input_pin));
endmodule // ctpg_host_checker
`default_nettype wire

/* dv/ctpg_dev_model.sv */
// Behavioural cascaded timer that answers the controller's byte writes.
// Assumes the controller and this model share the system clock; PWM and pulse counts tick every cycle.
`default_nettype none
module ctpg_dev_model #(
   parameter int unsigned OVF = 65536
) (
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   input wire logic i_wr,
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_evt,
   output logic o_irq,
   output logic [15:0] o_count,
   output logic [15:0] o_duty_rd,
   output logic [15:0] o_duty_act,
   output logic o_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] per, nxt, wst;
   logic [7:0] upper;
   logic flop, evt_q, run, ovf;
   logic [2:0] mode;
   assign run = upper[3];
   assign mode = upper[2:0];
   assign nxt = o_count + 16'h0001;
   assign ovf = o_count == 16'(OVF - 1);
   assign o_pin = ~flop;
   // A read returns the transferred duty, so a fresh write stays hidden until the transfer.
   assign o_duty_rd = o_duty_act;
   // Register writes, the shadow duty stage and the three counting modes.
   always_ff @(posedge i_sys_clk) begin
      o_irq <= 1'b0;
      evt_q <= i_evt;
      if (!i_nrst) begin
         upper <= 8'h00;
         per <= 16'h0000;
         o_count <= 16'h0000;
         wst <= 16'h0000;
         o_duty_act <= 16'h0000;
         flop <= 1'b0;
      end else begin
         if (i_wr && i_addr == ctpg_pkg::ADDR_PERIOD_LOW) per[7:0] <= i_wdata;
         if (i_wr && i_addr == ctpg_pkg::ADDR_PERIOD_HIGH) per[15:8] <= i_wdata;
         if (i_wr && i_addr == ctpg_pkg::ADDR_DUTY_LOW) wst[7:0] <= i_wdata;
         if (i_wr && i_addr == ctpg_pkg::ADDR_DUTY_HIGH) wst[15:8] <= i_wdata;
         if (i_wr && i_addr == ctpg_pkg::ADDR_UPPER_CTRL) upper <= i_wdata;
         // The flop follows the initial bit only once stopped, so a stop keeps the pin.
         if (i_wr && i_addr == ctpg_pkg::ADDR_UPPER_CTRL && !run) flop <= i_wdata[7];
         if (!(run && mode == ctpg_pkg::MODE_PWM)) o_duty_act <= wst;
         if (!run) o_count <= 16'h0000;
         else if (mode == ctpg_pkg::MODE_EVENT && evt_q && !i_evt) begin
            o_count <= (nxt == per) ? 16'h0000 : nxt;
            o_irq <= nxt == per;
         end else if (mode == ctpg_pkg::MODE_PWM) begin
            flop <= flop ^ (nxt == o_duty_act) ^ ovf;
            o_count <= ovf ? 16'h0000 : nxt;
            o_irq <= ovf;
            if (ovf) o_duty_act <= wst;
         end else if (mode == ctpg_pkg::MODE_PPG) begin
            flop <= flop ^ (nxt == o_duty_act) ^ (nxt == per);
            o_count <= (nxt == per) ? 16'h0000 : nxt;
            o_irq <= nxt == per;
         end
      end
   end
endmodule // ctpg_dev_model
`default_nettype wire

/* dv/ctpg_host_tb.sv */
// Self-checking bench: controller drives the timer model; writes match a queue model.
// Assumes the checker and timer model are compiled before this file.
`default_nettype none
module ctpg_host_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int OVF_T = 64;
   logic i_sys_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic v = 1'b0, pre = 1'b0, fi = 1'b0, fh = 1'b0, init = 1'b0;
   logic [2:0] op = 3'h0, cs = 3'h0, mode = 3'h0;
   logic [15:0] per = 16'h0000, dut = 16'h0000, evn = 16'h0000, cnt, drd, dact;
   logic rdy, done, slp, wr, pin, irq, dpin;
   logic [3:0] addr;
   logic [7:0] wd;
   logic [11:0] exp_q[$];
   logic [31:0] seed = 32'he954;
   int n_fail = 0, compares = 0, n_irq = 0;
   always #5 i_sys_clk = ~i_sys_clk;
   ctpg_host #(.EVT_LEVEL_CYC(2)) ctpg_host_i (.i_sys_clk, .i_nrst, .i_cmd_valid(v),
      .i_cmd_op(op), .i_cmd_period(per), .i_cmd_duty(dut), .i_cmd_clk_sel(cs),
      .i_cmd_prescale(pre), .i_cmd_flop_init(fi), .i_cmd_force_high(fh), .i_cmd_events(evn),
      .i_match_irq(irq), .o_cmd_ready(rdy), .o_cmd_done(done), .o_sleep_ok(slp),
      .o_reg_wr(wr), .o_reg_addr(addr), .o_reg_wdata(wd), .o_event_input_pin(pin));
   ctpg_dev_model #(.OVF(OVF_T)) ctpg_dev_model_i (.i_sys_clk, .i_nrst, .i_wr(wr),
      .i_addr(addr), .i_wdata(wd), .i_evt(pin), .o_irq(irq), .o_count(cnt),
      .o_duty_rd(drd), .o_duty_act(dact), .o_pin(dpin));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic put(input logic [3:0] a, input logic [7:0] d);
      exp_q.push_back({a, d});
   endtask
   task automatic give_verdict();
      if (n_fail == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Counts every cycle and low-pin cycle up to the next match interrupt.
   task automatic gap(output int c, output int lo);
      c = 0;
      lo = 0;
      do begin
         @(posedge i_sys_clk);
         c++;
         lo += (dpin === 1'b0);
      end while (irq !== 1'b1 && c < 5000);
   endtask
   // Queues the expected byte writes of a command, then hands it over and awaits done.
   task automatic run(input logic [2:0] o, input logic [15:0] p, input logic [15:0] d,
         input logic f, input logic h, input logic [15:0] e);
      logic [31:0] r;
      logic [2:0] m;
      r = rnd();
      m = ctpg_pkg::MODE_EVENT + o;
      if (o <= ctpg_pkg::OP_START_PPG) begin
         mode = m;
         init = f && o != ctpg_pkg::OP_START_EVENT;
         cs <= r[2:0];
         pre <= r[3];
         put(ctpg_pkg::ADDR_PORT_LATCH, ctpg_pkg::PORT_LATCH_ON);
         put(ctpg_pkg::ADDR_UPPER_CTRL, {5'h00, m});
         put(ctpg_pkg::ADDR_PERIOD_LOW, p[7:0]);
         put(ctpg_pkg::ADDR_PERIOD_HIGH, p[15:8]);
         put(ctpg_pkg::ADDR_DUTY_LOW, d[7:0]);
         put(ctpg_pkg::ADDR_DUTY_HIGH, d[15:8]);
         put(ctpg_pkg::ADDR_LOWER_CTRL, {1'b0, m, r[3:0]});
         put(ctpg_pkg::ADDR_UPPER_CTRL, {init, 4'h0, m});
         put(ctpg_pkg::ADDR_UPPER_CTRL, {init, 4'h1, m});
      end else if (o == ctpg_pkg::OP_SET_DUTY) begin
         put(ctpg_pkg::ADDR_DUTY_LOW, d[7:0]);
         put(ctpg_pkg::ADDR_DUTY_HIGH, d[15:8]);
      end else if (o == ctpg_pkg::OP_STOP) begin
         put(ctpg_pkg::ADDR_UPPER_CTRL, {init, 4'h0, mode});
         if (h) put(ctpg_pkg::ADDR_UPPER_CTRL, {5'h00, mode});
         if (h) init = 1'b0;
      end
      op <= o;
      per <= p;
      dut <= d;
      fi <= f;
      fh <= h;
      evn <= e;
      v <= 1'b1;
      @(posedge i_sys_clk);
      for (int i = 0; i < 40 && rdy !== 1'b1; i++) @(posedge i_sys_clk);
      v <= 1'b0;
      for (int i = 0; i < 5000 && done !== 1'b1; i++) @(posedge i_sys_clk);
      chk(16'(done), 16'h0001);
      chk(16'(rdy), 16'h0000);
      @(posedge i_sys_clk);
      chk(16'(rdy), 16'h0001);
   endtask
   // Every write is compared with the queue; interrupts are counted.
   always @(posedge i_sys_clk) begin
      if (i_nrst && wr === 1'b1 && exp_q.size() == 0) chk({4'h0, addr, wd}, 16'hffff);
      else if (i_nrst && wr === 1'b1) chk({4'h0, addr, wd}, {4'h0, exp_q.pop_front()});
      if (irq === 1'b1) n_irq++;
   end
   // Main sequence of scenarios.
   initial begin
      logic [31:0] r;
      int c, lo, ev, dd;
      logic p0;
      repeat (3) @(posedge i_sys_clk);
      chk({14'h0000, slp, pin}, 16'h0003);
      i_nrst <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         r = rnd();
         run(3'(k), r[15:0], r[31:16], r[4], 1'b0, 16'h0000);
         chk(16'(slp), 16'h0000);
         run(ctpg_pkg::OP_STOP, 16'h0000, 16'h0000, 1'b0, r[5], 16'h0000);
         chk(16'(slp), 16'h0001);
      end
      // Falling edges on the event pin feed the counter and its period match.
      ev = int'(rnd() & 32'h0000000f) + 1;
      run(ctpg_pkg::OP_START_EVENT, 16'h0003, 16'h0000, 1'b1, 1'b0, 16'h0000);
      n_irq = 0;
      run(ctpg_pkg::OP_SEND_EVENTS, 16'h0000, 16'h0000, 1'b0, 1'b0, 16'(ev));
      repeat (4) @(posedge i_sys_clk);
      chk(16'(n_irq), 16'(ev / 3));
      chk(cnt, 16'(ev % 3));
      run(ctpg_pkg::OP_STOP, 16'h0000, 16'h0000, 1'b0, 1'b0, 16'h0000);
      // A duty change during pulse-width output waits for the next interrupt.
      run(ctpg_pkg::OP_START_PWM, 16'h0000, 16'h000a, 1'b0, 1'b0, 16'h0000);
      run(ctpg_pkg::OP_SET_DUTY, 16'h0000, 16'h0014, 1'b0, 1'b0, 16'h0000);
      chk(drd, 16'h000a);
      chk(dact, 16'h000a);
      gap(c, lo);
      gap(c, lo);
      chk(dact, 16'h0014);
      chk(drd, 16'h0014);
      chk(16'(c), 16'(OVF_T));
      chk(16'(lo), 16'(OVF_T - 20));
      run(ctpg_pkg::OP_STOP, 16'h0000, 16'h0000, 1'b0, 1'b0, 16'h0000);
      p0 = dpin;
      repeat (80) @(posedge i_sys_clk);
      chk(16'(dpin), 16'(p0));
      run(ctpg_pkg::OP_STOP, 16'h0000, 16'h0000, 1'b0, 1'b1, 16'h0000);
      chk(16'(dpin), 16'h0001);
      // Programmable pulses with a random period, duty and polarity.
      r = rnd();
      ev = 16 + int'(r[4:0]);
      dd = 1 + int'(r[10:8]);
      run(ctpg_pkg::OP_START_PPG, 16'(ev), 16'(dd), r[16], 1'b0, 16'h0000);
      gap(c, lo);
      gap(c, lo);
      chk(16'(c), 16'(ev));
      chk(16'(lo), 16'(r[16] ? dd : ev - dd));
      run(ctpg_pkg::OP_STOP, 16'h0000, 16'h0000, 1'b0, 1'b1, 16'h0000);
      chk(16'(dpin), 16'h0001);
      chk(16'(exp_q.size()), 16'h0000);
      give_verdict();
   end
   // The whole run takes several hundred cycles; this cuts a hang short.
   initial begin
      #300000;
      n_fail++;
      give_verdict();
   end
endmodule // ctpg_host_tb
bind ctpg_host ctpg_host_checker #(.EVT_LEVEL_CYC(EVT_LEVEL_CYC)) ctpg_host_checker_i (
   .i_sys_clk, .i_nrst, .i_cmd_valid, .i_cmd_op, .o_cmd_ready, .o_sleep_ok, .o_reg_wr,
   .o_reg_addr, .o_reg_wdata, .o_event_input_pin);
`default_nettype wire
